// [inc/rtosu_pkg.sv]
// rtosu_pkg: constants and carrier types for the terminal status register (upper half).
// assumes a single 25 MHz system clock; no other package is needed.
`default_nettype none

package rtosu_pkg;

    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ   = 25_000_000;
    localparam int unsigned CLK_PERIOD_NS = 40;
    // post-reset internal initialization time (ram clear and similar)
    localparam int unsigned INIT_TIME_NS  = 2000;
    // longest-time figure would round down, a least time rounds up
    localparam int unsigned INIT_CYCLES   =
        (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [15:0] OPSTAT_OFFSET = 16'h0002;
    localparam int unsigned DATA_W        = 16;

    // field positions
    localparam int unsigned ADDR_MSB      = 15;
    localparam int unsigned ADDR_LSB      = 11;
    localparam int unsigned PARITY_BIT    = 10;
    localparam int unsigned LOCK_BIT      = 9;
    localparam int unsigned AUTO_INIT_ENABLE_BIT    = 8;
    localparam int unsigned READY_BIT     = 7;
    localparam int unsigned ACTIVE_BIT    = 6;
    localparam int unsigned LOW_W         = 6;

    // reset values of the register-held fields
    localparam logic [4:0]  ADDR_RST      = 5'h00;
    localparam logic        PARITY_RST    = 1'b0;
    localparam logic        LOCK_RST      = 1'b0;
    localparam logic        AUTO_INIT_ENABLE_RST    = 1'b0;
    localparam logic [15:0] RDATA_RST     = 16'h0000;

    // ---------------------------------------------------------------
    // carrier types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [4:0] terminal_address;
        logic       terminal_address_parity;
        logic       lock;
    } rtosu_strap_type;

    typedef struct packed {
        logic        en;
        logic [15:0] data;
    } rtosu_write_type;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_INIT = 3'b001,
        ST_AUTO = 3'b011,
        ST_WAIT = 3'b010,
        ST_RUN  = 3'b110
    } rtosu_state_type;

endpackage

`default_nettype wire

// [core/rtosu_seq.sv]
// rtosu_seq: post-reset sequencer giving ready, auto-init start and terminal run.
// assumes master_reset_n is synchronous to clk_sys and held low at least one edge.
`timescale 1ns/10ps
`default_nettype none

module rtosu_seq
#(
    parameter int unsigned INIT_CNT = rtosu_pkg::INIT_CYCLES
)
(
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic                     ce,
    // master reset level and its release strobe
    input  wire logic                     master_reset_n,
    input  wire logic                     mr_release,
    // sampled strap and configuration
    input  wire logic                     auto_init_enable,
    input  wire logic                     terminal_execute,
    input  wire logic                     auto_init_done,
    // sequencer outputs
    output logic                          ready,
    output logic                          auto_init_start,
    output logic                          auto_init_busy,
    output logic                          terminal_run,
    output rtosu_pkg::rtosu_state_type    state
);
    import rtosu_pkg::*;

    localparam int unsigned CW = (INIT_CNT < 2) ? 1 : $clog2(INIT_CNT + 1);

    initial
    begin
        if (INIT_CNT < 1)
            $error("rtosu_seq: INIT_CNT must be at least one cycle");
    end

    rtosu_state_type state_q;
    rtosu_state_type state_d;
    logic [CW-1:0]   cnt_q;
    logic            start_q;

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            state_q <= ST_HOLD;
        else if (ce)
            state_q <= state_d;
    end

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_HOLD:
                if (mr_release)
                    state_d = ST_INIT;
            ST_INIT:
                if (cnt_q == CW'(INIT_CNT - 1))
                    state_d = auto_init_enable ? ST_AUTO : ST_WAIT;
            ST_AUTO:
                if (auto_init_done)
                    state_d = ST_WAIT;
            ST_WAIT:
                // auto-init may itself have set execute
                if (terminal_execute)
                    state_d = ST_RUN;
            ST_RUN:
                if (!terminal_execute)
                    state_d = ST_WAIT;
        endcase
        // master reset overrides every state
        if (!master_reset_n)
            state_d = ST_HOLD;
    end

    // ---------------------------------------------------------------
    // init counter and auto-init start pulse
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cnt_q <= '0;
        else if (ce)
        begin
            if (state_q == ST_INIT)
                cnt_q <= cnt_q + CW'(1);
            else
                cnt_q <= '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            start_q <= 1'b0;
        else if (ce)
            start_q <= (state_q == ST_INIT) && (state_d == ST_AUTO);
    end

    // ready once internal init is over; ram then accepts config data
    assign ready           = (state_q == ST_AUTO) || (state_q == ST_WAIT) ||
                             (state_q == ST_RUN);
    assign auto_init_start = start_q;
    assign auto_init_busy  = (state_q == ST_AUTO);
    assign terminal_run    = (state_q == ST_RUN);
    assign state           = state_q;

endmodule

`default_nettype wire

// [core/rtosu_status.sv]
// rtosu_status: upper ten bits of the terminal operational status register.
// assumes host and auto-init write ports are synchronous to clk_sys; low six
// bits are produced elsewhere and only passed through on read.
`timescale 1ns/10ps
`default_nettype none

module rtosu_status
#(
    parameter int unsigned INIT_CNT = rtosu_pkg::INIT_CYCLES
)
(
    // clock, reset, enable
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic                     ce,
    // master reset pin and strap pins
    input  wire logic                     master_reset_n,
    input  wire rtosu_pkg::rtosu_strap_type strap,
    input  wire logic                     auto_init_enable_pin,
    // host register port
    input  wire logic [15:0]              host_addr,
    input  wire logic                     host_rd,
    input  wire rtosu_pkg::rtosu_write_type host_wr,
    output logic [15:0]                   host_rdata,
    output logic                          host_rvalid,
    // auto-initialization engine
    input  wire rtosu_pkg::rtosu_write_type ai_wr,
    input  wire logic                     auto_init_done,
    output logic                          auto_init_start,
    output logic                          auto_init_busy,
    // terminal side
    input  wire logic                     terminal_execute,
    input  wire logic                     valid_command,
    input  wire logic                     command_done,
    input  wire logic [5:0]               status_low,
    // status pins
    output logic                          ready,
    output logic                          active,
    output logic                          terminal_run,
    output logic [4:0]                    terminal_address,
    output logic                          terminal_address_parity,
    output logic                          address_locked
);
    import rtosu_pkg::*;

    initial
    begin
        if (INIT_CNT < 1)
            $error("rtosu_status: INIT_CNT must be at least one cycle");
    end

    // ---------------------------------------------------------------
    // master reset release detect
    // ---------------------------------------------------------------
    logic mr_n_q;
    logic mr_release;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            mr_n_q <= 1'b0;
        else if (ce)
            mr_n_q <= master_reset_n;
    end

    // pins are synchronous, so a plain edge detect is safe here
    assign mr_release = master_reset_n && !mr_n_q;

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    logic            auto_init_enable_q;
    logic            seq_ready;

    rtosu_seq
    #(
        .INIT_CNT (INIT_CNT)
    )
    u_seq
    (
        .clk_sys          (clk_sys),
        .rst              (rst),
        .ce               (ce),
        .master_reset_n   (master_reset_n),
        .mr_release       (mr_release),
        .auto_init_enable (auto_init_enable_q),
        .terminal_execute (terminal_execute),
        .auto_init_done   (auto_init_done),
        .ready            (seq_ready),
        .auto_init_start  (auto_init_start),
        .auto_init_busy   (auto_init_busy),
        .terminal_run     (terminal_run),
        .state            ()
    );

    // ---------------------------------------------------------------
    // write arbitration
    // ---------------------------------------------------------------
    logic            host_hit;
    logic            wr_en;
    logic [15:0]     wr_data;
    logic            field_writable;

    assign host_hit = (host_addr == OPSTAT_OFFSET);

    // auto-init owns the register while it runs; host writes then dropped
    always_comb
    begin
        wr_en   = 1'b0;
        wr_data = '0;
        if (auto_init_busy && ai_wr.en)
        begin
            wr_en   = 1'b1;
            wr_data = ai_wr.data;
        end
        else if (!auto_init_busy && host_wr.en && host_hit)
        begin
            wr_en   = 1'b1;
            wr_data = host_wr.data;
        end
    end

    // writes reach the upper fields only when unlocked and not executing
    assign field_writable = !address_locked && !terminal_execute;

    // ---------------------------------------------------------------
    // address, parity and lock fields
    // ---------------------------------------------------------------
    logic [4:0] addr_q;
    logic       parity_q;
    logic       lock_q;

    // besides writes, only rst and master reset touch these; no soft reset input exists
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            addr_q   <= ADDR_RST;
            parity_q <= PARITY_RST;
        end
        else if (ce)
        begin
            if (mr_release)
            begin
                addr_q   <= strap.terminal_address;
                parity_q <= strap.terminal_address_parity;
            end
            else if (wr_en && field_writable)
            begin
                addr_q   <= wr_data[ADDR_MSB:ADDR_LSB];
                parity_q <= wr_data[PARITY_BIT];
            end
            // other writes leave the fields as they are
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            lock_q <= LOCK_RST;
        else if (ce)
        begin
            if (mr_release)
                lock_q <= strap.lock;
            else if (wr_en && field_writable && wr_data[LOCK_BIT])
                lock_q <= 1'b1;
            // set lock sticks: nothing but rst or master reset clears it
        end
    end

    // ---------------------------------------------------------------
    // auto-init enable capture
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            auto_init_enable_q <= AUTO_INIT_ENABLE_RST;
        else if (ce && mr_release)
            auto_init_enable_q <= auto_init_enable_pin;
    end

    // ---------------------------------------------------------------
    // active flag
    // ---------------------------------------------------------------
    logic active_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            active_q <= 1'b0;
        else if (ce)
        begin
            if (!master_reset_n)
                active_q <= 1'b0;
            else if (valid_command && terminal_run)
                active_q <= 1'b1;
            else if (command_done || !terminal_run)
                active_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // ready flag
    // ---------------------------------------------------------------
    logic ready_q;

    // registered so the pin and bit 7 are the same flop
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            ready_q <= 1'b0;
        else if (ce)
            ready_q <= seq_ready && master_reset_n;
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    logic [15:0] status_word;
    logic [15:0] rdata_q;
    logic        rvalid_q;

    always_comb
    begin
        status_word                    = '0;
        status_word[ADDR_MSB:ADDR_LSB] = addr_q;
        status_word[PARITY_BIT]        = parity_q;
        status_word[LOCK_BIT]          = lock_q;
        status_word[AUTO_INIT_ENABLE_BIT]        = auto_init_enable_q;
        status_word[READY_BIT]         = ready_q;
        status_word[ACTIVE_BIT]        = active_q;
        status_word[LOW_W-1:0]         = status_low;
    end

    // unmapped address reads back zero
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rdata_q  <= RDATA_RST;
            rvalid_q <= 1'b0;
        end
        else if (ce)
        begin
            rvalid_q <= host_rd;
            if (host_rd)
                rdata_q <= host_hit ? status_word : RDATA_RST;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign host_rdata              = rdata_q;
    assign host_rvalid             = rvalid_q;
    assign ready                   = ready_q;
    assign active                  = active_q;
    assign terminal_address        = addr_q;
    assign terminal_address_parity = parity_q;
    assign address_locked          = lock_q;

endmodule

`default_nettype wire

// [verification/rtosu_ai_model.sv]
// rtosu_ai_model: auto-init engine at the far side of the status register.
// assumes start is a one-cycle pulse; dly of 2 or more sets the answer time.
`timescale 1ns/10ps
`default_nettype none

module rtosu_ai_model
(
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // control from the bench and the block
    input  wire logic                   start,
    input  wire logic [3:0]             dly,
    input  wire logic [15:0]            word,
    // engine outputs
    output rtosu_pkg::rtosu_write_type  ai_wr,
    output logic                        done
);
    import rtosu_pkg::*;
    logic [3:0] cnt_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 4'h0;
            ai_wr <= '0;
            done  <= 1'b0;
        end
        else
        begin
            // idle bus shows the inverse, never a stale word
            ai_wr <= '{1'b0, ~word};
            done  <= 1'b0;
            if (start)
                cnt_q <= dly;
            else if (cnt_q != 4'h0)
                cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h2)
                ai_wr <= '{1'b1, word};
            if (cnt_q == 4'h1)
                done <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// [verification/rtosu_status_assertions.sv]
// rtosu_status_assertions: port-level checks of the status register block.
// assumes it is bound into rtosu_status; one clock domain.
`timescale 1ns/10ps
`default_nettype none

module rtosu_status_assertions
#(
    parameter int unsigned INIT_CNT = rtosu_pkg::INIT_CYCLES
)
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    // pins and status
    input  wire logic        master_reset_n,
    input  wire logic        terminal_execute,
    input  wire logic        valid_command,
    input  wire logic        command_done,
    input  wire logic [5:0]  status_low,
    input  wire logic        ready,
    input  wire logic        active,
    input  wire logic        terminal_run,
    input  wire logic [4:0]  terminal_address,
    input  wire logic        terminal_address_parity,
    input  wire logic        address_locked,
    input  wire logic        auto_init_start,
    input  wire logic        auto_init_busy,
    // host port
    input  wire logic [15:0] host_addr,
    input  wire logic        host_rd,
    input  wire logic [15:0] host_rdata,
    input  wire logic        host_rvalid
);
    import rtosu_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ---------------------------------------------------------------
    // helper: no master reset release at this edge
    // ---------------------------------------------------------------
    logic mr_seen_q;
    logic steady;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            mr_seen_q <= 1'b0;
        else if (ce)
            mr_seen_q <= master_reset_n;
    end
    assign steady = ce && master_reset_n && mr_seen_q;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_lock_freeze: assert property (steady && address_locked |=>
        $stable({terminal_address, terminal_address_parity})) else $error("locked address moved");
    a_lock_sticky: assert property (steady && address_locked |=> address_locked)
        else $error("lock cleared without master reset");
    a_exec_block: assert property (steady && terminal_execute |=>
        $stable({terminal_address, terminal_address_parity, address_locked}))
        else $error("field changed while executing");
    a_ready_drop: assert property (ce && !master_reset_n |=> !ready)
        else $error("ready high in master reset");
    a_run_execute: assert property (ce && !terminal_execute |=> !terminal_run)
        else $error("run without execute");
    a_active_cause: assert property ($rose(active) |->
        $past(valid_command) && $past(terminal_run)) else $error("active without command");
    a_active_end: assert property (ce && active && command_done && !valid_command |=>
        !active) else $error("active stayed after done");
    a_rvalid_pulse: assert property (ce |=> host_rvalid == $past(host_rd))
        else $error("rvalid not one cycle after read");
    a_rdata_map: assert property (host_rvalid && $past(host_addr) == OPSTAT_OFFSET |->
        {host_rdata[15:9], host_rdata[7:0]} == {$past(terminal_address),
        $past(terminal_address_parity), $past(address_locked), $past(ready),
        $past(active), $past(status_low)}) else $error("read word mismatch");
    a_ai_start: assert property (auto_init_start |-> auto_init_busy)
        else $error("start without busy");

    c_ready: cover property ($rose(ready));
    c_active: cover property ($rose(active));
    c_autoinit: cover property (auto_init_start);
    c_locked: cover property ($rose(address_locked));
endmodule

bind rtosu_status rtosu_status_assertions #(.INIT_CNT(INIT_CNT)) rtosu_status_assertions_inst (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .master_reset_n(master_reset_n),
    .terminal_execute(terminal_execute), .valid_command(valid_command),
    .command_done(command_done), .status_low(status_low), .ready(ready), .active(active),
    .terminal_run(terminal_run), .terminal_address(terminal_address),
    .terminal_address_parity(terminal_address_parity), .address_locked(address_locked),
    .auto_init_start(auto_init_start), .auto_init_busy(auto_init_busy),
    .host_addr(host_addr), .host_rd(host_rd), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid));

`default_nettype wire

// [verification/testbench.sv]
// testbench: self-checking bench of the status register, upper half.
// assumes rtosu_status and the auto-init model; ce and status_low tied.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import rtosu_pkg::*;
    localparam int unsigned INIT_N = 4;
    logic            clk_sys = 1'b0;
    logic            rst = 1'b1;
    logic            master_reset_n = 1'b0;
    rtosu_strap_type strap = '0;
    logic            aen = 1'b0;
    logic [15:0]     host_addr = 16'h0000;
    logic            host_rd = 1'b0;
    rtosu_write_type host_wr = '0;
    rtosu_write_type ai_wr;
    logic            ai_done, ai_start, ai_busy;
    logic            exec = 1'b0, vcmd = 1'b0, cdone = 1'b0;
    logic [3:0]      dly = 4'h2;
    logic [15:0]     host_rdata, rd_q;
    logic            host_rvalid, ready, active, run, tap, locked;
    logic [4:0]      ta;
    int              fail_count = 0, num_checks = 0, cyc = 0;

    always #20 clk_sys = ~clk_sys;

    rtosu_status #(.INIT_CNT(INIT_N)) rtosu_status_inst (
        .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .master_reset_n(master_reset_n),
        .strap(strap), .auto_init_enable_pin(aen), .host_addr(host_addr),
        .host_rd(host_rd), .host_wr(host_wr), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .ai_wr(ai_wr), .auto_init_done(ai_done),
        .auto_init_start(ai_start), .auto_init_busy(ai_busy), .terminal_execute(exec),
        .valid_command(vcmd), .command_done(cdone), .status_low(6'h2a), .ready(ready),
        .active(active), .terminal_run(run), .terminal_address(ta),
        .terminal_address_parity(tap), .address_locked(locked));
    rtosu_ai_model rtosu_ai_model_inst (.clk_sys(clk_sys), .rst(rst), .start(ai_start),
        .dly(dly), .word(16'hac00), .ai_wr(ai_wr), .done(ai_done));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
            fail_count++;
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        host_addr <= a;
        host_wr <= '{1'b1, d};
        @(posedge clk_sys);
        host_wr <= '{1'b0, ~d};
    endtask

    task automatic rd(input logic [15:0] a);
        @(posedge clk_sys);
        host_addr <= a;
        host_rd <= 1'b1;
        @(posedge clk_sys);
        host_rd <= 1'b0;
        #1;
        chk("rvalid", 16'h1, {15'h0, host_rvalid});
        rd_q = host_rdata;
    endtask

    task automatic mreset(input rtosu_strap_type s, input logic a);
        int n;
        @(posedge clk_sys);
        master_reset_n <= 1'b0;
        strap <= s;
        aen <= a;
        repeat (3) @(posedge clk_sys);
        #1 chk("ready_low", 16'h0, {15'h0, ready});
        @(posedge clk_sys);
        master_reset_n <= 1'b1;
        n = 0;
        while (ready !== 1'b1 && n < 100)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk("ready_wait", 16'h1, {15'h0, n >= INIT_N && n < 100});
        // straps move after release: fields must not follow them
        strap <= ~s;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_strap;
        for (int lk = 0; lk < 2; lk++)
        begin
            mreset('{5'h0a, 1'b1, lk[0]}, 1'b0);
            rd(OPSTAT_OFFSET);
            chk("strap", {8'h0, 5'h0a, 1'b1, lk[0], 1'b0}, {8'h0, rd_q[15:8]});
        end
    endtask

    task automatic t_host;
        mreset('{5'h03, 1'b0, 1'b0}, 1'b0);
        wr(OPSTAT_OFFSET, 16'hf8ff);
        rd(OPSTAT_OFFSET);
        chk("wr_open", 16'hf880, {rd_q[15:6], 6'h0});
        exec <= 1'b1;
        wr(OPSTAT_OFFSET, 16'h0600);
        rd(OPSTAT_OFFSET);
        chk("wr_exec", 16'h00f8, {8'h0, rd_q[15:8]});
        exec <= 1'b0;
        wr(OPSTAT_OFFSET, 16'h0600);
        rd(OPSTAT_OFFSET);
        chk("wr_lock", 16'h0006, {8'h0, rd_q[15:8]});
        wr(OPSTAT_OFFSET, 16'hf800);
        rd(OPSTAT_OFFSET);
        chk("wr_locked", 16'h0006, {8'h0, rd_q[15:8]});
        wr(16'h0003, 16'hf800);
        rd(16'h0003);
        chk("unmapped", 16'h0000, rd_q);
        mreset('{5'h11, 1'b0, 1'b0}, 1'b0);
        #1 chk("unlock", 16'h0044, {9'h0, ta, tap, locked});
    endtask

    task automatic t_auto(input logic [3:0] d);
        int n;
        dly <= d;
        exec <= 1'b0;
        mreset('{5'h01, 1'b0, 1'b0}, 1'b1);
        n = 0;
        while (ai_busy !== 1'b0 && n < 50)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk("busy_len", 16'(d) + 16'h1, 16'(n));
        rd(OPSTAT_OFFSET);
        chk("auto_word", 16'h00ad, {8'h0, rd_q[15:8]});
        repeat (3) @(posedge clk_sys);
        chk("run_wait", 16'h0, {15'h0, run});
        exec <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 chk("run_go", 16'h1, {15'h0, run});
    endtask

    task automatic t_active;
        @(posedge clk_sys);
        vcmd <= 1'b1;
        @(posedge clk_sys);
        vcmd <= 1'b0;
        #1 chk("act_set", 16'h1, {15'h0, active});
        rd(OPSTAT_OFFSET);
        chk("act_bit", 16'h1, {15'h0, rd_q[6]});
        @(posedge clk_sys);
        cdone <= 1'b1;
        @(posedge clk_sys);
        cdone <= 1'b0;
        #1 chk("act_clr", 16'h0, {15'h0, active});
        exec <= 1'b0;
        repeat (2) @(posedge clk_sys);
        vcmd <= 1'b1;
        @(posedge clk_sys);
        vcmd <= 1'b0;
        #1 chk("act_idle", 16'h0, {15'h0, active});
    endtask

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            end_sim;
        end
    end

    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_strap;
        t_host;
        t_auto(4'h2);
        t_auto(4'h9);
        t_active;
        end_sim;
    end
endmodule

`default_nettype wire
